// ===== core/xpd_params.svh
// Constants for the exchange and port-input decoder
`ifndef XPD_PARAMS_SVH
`define XPD_PARAMS_SVH
`define XPD_SWAP_RM_PAT   7'h43
`define XPD_SWAP_ACC_PAT  5'h12
`define XPD_IN_FIX_PAT    7'h72
`define XPD_IN_VAR_PAT    7'h76
`define XPD_MOD_REG       2'h3
`define XPD_CYC_SWAP_REG  5'h04
`define XPD_CYC_SWAP_MEM  5'h11
`define XPD_CYC_SWAP_ACC  5'h03
`define XPD_CYC_IN_FIX    5'h0a
`define XPD_CYC_IN_VAR    5'h08
`endif

// ===== core/xpd_pkg.sv
// Types for the exchange and port-input decoder
package xpd_pkg;
  typedef enum logic [2:0] {
    XPD_OP_NONE,
    XPD_OP_SWAP_RM,
    XPD_OP_SWAP_ACC,
    XPD_OP_IN_FIXED,
    XPD_OP_IN_VAR
  } xpd_op_t;
endpackage

// ===== core/xpd_match.sv
// Opcode pattern classifier for one opcode byte
`timescale 1ns/1ps
`include "xpd_params.svh"
module xpd_match (
  input  wire logic [7:0] opcode_i,
  output logic            swap_rm_o,
  output logic            swap_acc_o,
  output logic            in_fix_o,
  output logic            in_var_o
);
  // Pure pattern compares, the width bit is ignored here
  assign swap_rm_o  = (opcode_i[7:1] == `XPD_SWAP_RM_PAT);
  assign swap_acc_o = (opcode_i[7:3] == `XPD_SWAP_ACC_PAT);
  assign in_fix_o   = (opcode_i[7:1] == `XPD_IN_FIX_PAT);
  assign in_var_o   = (opcode_i[7:1] == `XPD_IN_VAR_PAT);
endmodule

// ===== core/xpd_decoder.sv
// Exchange and port-input instruction decoder
`timescale 1ns/1ps
`include "xpd_params.svh"
module xpd_decoder (
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic        byte_valid_i,
  input  wire logic [7:0]  byte_i,
  input  wire logic [15:0] dx_value_i,
  output logic             dec_valid_o,
  output xpd_pkg::xpd_op_t dec_op_o,
  output logic             dec_word_o,
  output logic             dec_mem_o,
  output logic [2:0]       dec_reg_o,
  output logic [2:0]       dec_rm_o,
  output logic [1:0]       dec_mod_o,
  output logic [15:0]      dec_port_o,
  output logic [4:0]       dec_cycles_o,
  output logic             dec_unknown_o
);
  typedef enum logic [1:0] {XPD_IDLE, XPD_WAIT_MODRM, XPD_WAIT_PORT} xpd_state_t;

  logic       rst_sync1_q;
  logic       rst_sync2_q;
  wire  logic rst_n = rst_sync2_q;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end

  // Decode state and width bit held across the two-byte forms
  xpd_state_t state_q;
  xpd_state_t state_d;
  logic       word_q;
  logic       word_d;

  // Pattern hits for the byte now on the stream
  wire logic m_swap_rm;
  wire logic m_swap_acc;
  wire logic m_in_fix;
  wire logic m_in_var;

  xpd_match u_match (
    .opcode_i   (byte_i),
    .swap_rm_o  (m_swap_rm),
    .swap_acc_o (m_swap_acc),
    .in_fix_o   (m_in_fix),
    .in_var_o   (m_in_var)
  );

  wire logic idle_byte  = byte_valid_i && (state_q == XPD_IDLE);
  wire logic modrm_byte = byte_valid_i && (state_q == XPD_WAIT_MODRM);
  wire logic port_byte  = byte_valid_i && (state_q == XPD_WAIT_PORT);
  wire logic modrm_reg  = (byte_i[7:6] == `XPD_MOD_REG);

  // Opcode first, then a second byte for the two-byte forms
  always_comb begin
    state_d = state_q;
    word_d  = word_q;
    unique case (state_q)
      XPD_IDLE: begin
        if (idle_byte && m_swap_rm) begin
          state_d = XPD_WAIT_MODRM;
          word_d  = byte_i[0];
        end else if (idle_byte && m_in_fix) begin
          state_d = XPD_WAIT_PORT;
          word_d  = byte_i[0];
        end
      end
      XPD_WAIT_MODRM: begin
        if (byte_valid_i) state_d = XPD_IDLE;
      end
      XPD_WAIT_PORT: begin
        if (byte_valid_i) state_d = XPD_IDLE;
      end
      default: state_d = XPD_IDLE; // Unused code recovers to idle
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= XPD_IDLE;
      word_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      word_q  <= word_d;
    end
  end

  // Completion strobes for each instruction form
  wire logic fin_swap_rm  = modrm_byte;
  wire logic fin_swap_acc = idle_byte && m_swap_acc;
  wire logic fin_in_fix   = port_byte;
  wire logic fin_in_var   = idle_byte && m_in_var;
  wire logic fin_any      = fin_swap_rm | fin_swap_acc | fin_in_fix | fin_in_var;
  wire logic unknown      = idle_byte && !(m_swap_rm | m_swap_acc | m_in_fix | m_in_var);

  // Cycle budget: memory swap costs far more than register swap
  wire logic [4:0] cyc_swap = modrm_reg ? `XPD_CYC_SWAP_REG : `XPD_CYC_SWAP_MEM;
  wire logic [4:0] cycles_d = fin_swap_rm  ? cyc_swap :
                              fin_swap_acc ? `XPD_CYC_SWAP_ACC :
                              fin_in_fix   ? `XPD_CYC_IN_FIX :
                              `XPD_CYC_IN_VAR;
  wire xpd_pkg::xpd_op_t op_d = fin_swap_rm  ? xpd_pkg::XPD_OP_SWAP_RM :
                                fin_swap_acc ? xpd_pkg::XPD_OP_SWAP_ACC :
                                fin_in_fix   ? xpd_pkg::XPD_OP_IN_FIXED :
                                xpd_pkg::XPD_OP_IN_VAR;
  // Port source: trailing byte for fixed, DX for variable
  wire logic [15:0] port_d = fin_in_fix ? {8'h00, byte_i} : dx_value_i;
  // Accumulator swap is always a word move
  wire logic word_pick = (fin_swap_rm | fin_in_fix) ? word_q :
                         fin_swap_acc ? 1'b1 : byte_i[0];

  // Result fields hold until the next completed decode; valid and unknown are reloaded every cycle
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      dec_valid_o   <= 1'b0;
      dec_unknown_o <= 1'b0;
      dec_op_o      <= xpd_pkg::XPD_OP_NONE;
      dec_word_o    <= 1'b0;
      dec_mem_o     <= 1'b0;
      dec_reg_o     <= 3'h0;
      dec_rm_o      <= 3'h0;
      dec_mod_o     <= 2'h0;
      dec_port_o    <= 16'h0000;
      dec_cycles_o  <= 5'h00;
    end else begin
      dec_valid_o   <= fin_any;
      dec_unknown_o <= unknown;
      if (fin_any) begin
        dec_op_o     <= op_d;
        dec_word_o   <= word_pick;
        dec_mem_o    <= fin_swap_rm && !modrm_reg;
        dec_reg_o    <= fin_swap_rm ? byte_i[5:3] : 3'h0;
        dec_rm_o     <= (fin_swap_rm || fin_swap_acc) ? byte_i[2:0] : 3'h0;
        dec_mod_o    <= fin_swap_rm ? byte_i[7:6] : 2'h0;
        dec_port_o   <= (fin_in_fix || fin_in_var) ? port_d : 16'h0000;
        dec_cycles_o <= cycles_d;
      end
    end
  end

  // Checks on the decoded results
  swap_reg_cyc_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    (modrm_byte && modrm_reg) |=> dec_valid_o && dec_cycles_o == 5'h04 && !dec_mem_o)
    else $error("register swap budget wrong");
  swap_mem_cyc_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    (modrm_byte && !modrm_reg) |=> dec_cycles_o == 5'h11 && dec_mem_o)
    else $error("memory swap budget wrong");
  swap_acc_cyc_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    (idle_byte && byte_i[7:3] == 5'h12) |=> dec_valid_o && dec_cycles_o == 5'h03
      && dec_op_o == xpd_pkg::XPD_OP_SWAP_ACC && dec_rm_o == $past(byte_i[2:0]))
    else $error("accumulator swap wrong");
  in_fix_seq_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    (idle_byte && byte_i[7:1] == 7'h72) ##1 byte_valid_i |=> dec_valid_o
      && dec_cycles_o == 5'h0a && dec_word_o == $past(byte_i[0], 2))
    else $error("fixed port input wrong");
  in_fix_port_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    port_byte |=> dec_port_o == {8'h00, $past(byte_i)})
    else $error("fixed port number wrong");
  in_var_cyc_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    (idle_byte && byte_i[7:1] == 7'h76) |=> dec_valid_o && dec_cycles_o == 5'h08
      && dec_port_o == $past(dx_value_i) && state_q == XPD_IDLE)
    else $error("variable port input wrong");
  swap_wait_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    (idle_byte && byte_i[7:1] == 7'h43) |=> !dec_valid_o && state_q == XPD_WAIT_MODRM)
    else $error("swap did not wait for mode byte");
  no_both_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    !(dec_valid_o && dec_unknown_o))
    else $error("valid and unknown together");

  // Fixed-port opcode must wait for its port byte before completing
  fix_wait_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    (idle_byte && byte_i[7:1] == 7'h72) |=> !dec_valid_o && state_q == XPD_WAIT_PORT)
    else $error("fixed port did not wait for port byte");

  // Idle cycles between opcode and port byte neither finish nor drop it
  port_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    (state_q == XPD_WAIT_PORT && !byte_valid_i) |=> state_q == XPD_WAIT_PORT && !dec_valid_o)
    else $error("port wait lost");

  // Variable-port width bit comes from the opcode itself, no extra byte
  var_width_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    (idle_byte && byte_i[7:1] == 7'h76) |=> dec_op_o == xpd_pkg::XPD_OP_IN_VAR
      && dec_word_o == $past(byte_i[0]) && !dec_mem_o)
    else $error("variable port width wrong");

  // Operand fields are copied straight from the mode byte
  swap_fields_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    modrm_byte |=> dec_op_o == xpd_pkg::XPD_OP_SWAP_RM && dec_reg_o == $past(byte_i[5:3])
      && dec_rm_o == $past(byte_i[2:0]) && dec_mod_o == $past(byte_i[7:6]))
    else $error("swap operand fields wrong");

  // Width bit of the swap opcode must survive the mode byte
  swap_word_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    (idle_byte && byte_i[7:1] == 7'h43) ##1 byte_valid_i
      |=> dec_word_o == $past(byte_i[0], 2))
    else $error("swap width bit wrong");

  // Short accumulator swap is a word move with no memory operand and no port
  acc_word_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    (idle_byte && byte_i[7:3] == 5'h12) |=> dec_word_o && !dec_mem_o
      && dec_port_o == 16'h0000)
    else $error("accumulator swap width wrong");

  // Opcode outside the four forms pulses unknown and completes nothing
  unknown_pulse_a: assert property (@(posedge clock_i) disable iff (!rst_n)
    (idle_byte && byte_i[7:1] != 7'h43 && byte_i[7:3] != 5'h12 && byte_i[7:1] != 7'h72
      && byte_i[7:1] != 7'h76) |=> dec_unknown_o && !dec_valid_o)
    else $error("unknown opcode not flagged");
endmodule

// ===== sim/xpd_fetch_model.sv
// Fetch-side model feeding instruction bytes to the decoder
`timescale 1ns/1ps
module xpd_fetch_model (
  input  wire logic        clock_i,
  output logic             byte_valid_o,
  output logic [7:0]       byte_o,
  output logic [15:0]      dx_value_o
);
  // Quiet bus at time zero
  initial begin
    byte_valid_o = 1'b0;
    byte_o       = 8'h00;
    dx_value_o   = 16'h0000;
  end
  // One stream byte per call, launched just after the edge
  task automatic put(input logic [7:0] b, input logic [15:0] dx);
    @(posedge clock_i);
    byte_valid_o <= 1'b1;
    byte_o       <= b;
    dx_value_o   <= dx;
  endtask
  // Idle bus inverts its data so stale bytes never look current
  task automatic gap();
    @(posedge clock_i);
    byte_valid_o <= 1'b0;
    byte_o       <= ~byte_o;
    dx_value_o   <= ~dx_value_o;
  endtask
endmodule

// ===== sim/xpd_decoder_tb.sv
// Self-checking bench for the exchange and port-input decoder
`timescale 1ns/1ps
module xpd_decoder_tb;
  logic             clock_i;
  logic             reset_n_i;
  logic             byte_valid_i;
  logic [7:0]       byte_i;
  logic [15:0]      dx_value_i;
  logic             dv;
  logic             du;
  logic             dw;
  logic             dm;
  xpd_pkg::xpd_op_t op;
  logic [2:0]       rg;
  logic [2:0]       rm;
  logic [1:0]       md;
  logic [15:0]      pt;
  logic [4:0]       cy;
  logic [35:0]      seen;
  int               n_errors = 0;
  int               compares = 0;
  int               ticks = 0;
  assign seen = {dv, du, op, dw, dm, rg, rm, md, pt, cy};
  xpd_fetch_model i_fetch (.clock_i(clock_i), .byte_valid_o(byte_valid_i), .byte_o(byte_i),
    .dx_value_o(dx_value_i));
  xpd_decoder i_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .byte_valid_i(byte_valid_i),
    .byte_i(byte_i), .dx_value_i(dx_value_i), .dec_valid_o(dv), .dec_op_o(op), .dec_word_o(dw),
    .dec_mem_o(dm), .dec_reg_o(rg), .dec_rm_o(rm), .dec_mod_o(md), .dec_port_o(pt),
    .dec_cycles_o(cy), .dec_unknown_o(du));
  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [35:0] got, input logic [35:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Expected decode bundle with the completion pulse set
  function automatic logic [35:0] ev(xpd_pkg::xpd_op_t o, logic w, logic m, logic [2:0] r,
      logic [2:0] f, logic [1:0] d, logic [15:0] p, logic [4:0] c);
    return {1'b1, 1'b0, o, w, m, r, f, d, p, c};
  endfunction
  task automatic t_swap_rm();
    logic [7:0]  mb [3] = '{8'hc1, 8'h46, 8'h3a};
    logic [35:0] want;
    for (int w = 0; w < 2; w++) for (int k = 0; k < 3; k++) begin
      want = ev(xpd_pkg::XPD_OP_SWAP_RM, 1'(w), mb[k][7:6] != 2'h3, mb[k][5:3], mb[k][2:0],
        mb[k][7:6], 16'h0000, (mb[k][7:6] == 2'h3) ? 5'h04 : 5'h11);
      i_fetch.put(8'h86 | 8'(w), 16'h0000);
      i_fetch.put(mb[k], 16'h0000);
      i_fetch.gap();
      #1 chk("swap rm", seen, want);
    end
  endtask
  // Back-to-back one-byte swaps, each result seen the cycle after its byte
  task automatic t_swap_acc();
    logic [35:0] want;
    for (int r = 0; r < 9; r++) begin
      want = ev(xpd_pkg::XPD_OP_SWAP_ACC, 1'b1, 1'b0, 3'h0,
        3'(r - 1), 2'h0, 16'h0000, 5'h03);
      if (r < 8) i_fetch.put(8'h90 | 8'(r), 16'h0000);
      else i_fetch.gap();
      if (r > 0) #1 chk("swap acc", seen, want);
    end
  endtask
  // Port byte looks like an opcode; first pass idles before it, second does not
  task automatic t_port_in();
    logic [35:0] want;
    for (int w = 0; w < 2; w++) begin
      want = ev(xpd_pkg::XPD_OP_IN_FIXED, 1'(w), 1'b0, 3'h0, 3'h0, 2'h0,
        {8'h00, 7'h43, 1'(w)}, 5'h0a);
      i_fetch.put(8'he4 | 8'(w), 16'h1234);
      if (w == 0) i_fetch.gap();
      i_fetch.put({7'h43, 1'(w)}, 16'h1234);
      i_fetch.gap();
      #1 chk("in fixed", seen, want);
      want = ev(xpd_pkg::XPD_OP_IN_VAR, 1'(w), 1'b0, 3'h0, 3'h0, 2'h0,
        16'h03f8 ^ 16'(w), 5'h08);
      i_fetch.put(8'hec | 8'(w), 16'h03f8 ^ 16'(w));
      i_fetch.gap();
      #1 chk("in var", seen, want);
    end
  endtask
  // Foreign opcode pulses unknown for one cycle only
  task automatic t_unknown();
    i_fetch.put(8'h00, 16'h0000);
    i_fetch.gap();
    #1 chk("unknown", {34'h0, dv, du}, 36'h1);
    @(posedge clock_i);
    #1 chk("pulse end", {34'h0, dv, du}, 36'h0);
  endtask
  // Mid-run reset clears all outputs and drops a half-taken swap
  task automatic t_reset();
    logic [35:0] want;
    want = ev(xpd_pkg::XPD_OP_SWAP_ACC, 1'b1, 1'b0, 3'h0, 3'h3, 2'h0, 16'h0000, 5'h03);
    i_fetch.put(8'h87, 16'h0000);
    i_fetch.gap();
    reset_n_i <= 1'b0;
    #1 chk("in reset", seen, {2'h0, xpd_pkg::XPD_OP_NONE, 31'h0});
    repeat (4) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
    #1 chk("after release", seen, {2'h0, xpd_pkg::XPD_OP_NONE, 31'h0});
    @(posedge clock_i);
    i_fetch.put(8'h93, 16'h0000);
    i_fetch.gap();
    #1 chk("swap acc after reset", seen, want);
  endtask
  // 40 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  // Hang guard well past the expected 60 or so cycles
  always @(posedge clock_i) begin
    ticks++;
    if (ticks == 2000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    reset_n_i = 1'b0;
    repeat (4) @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    t_swap_rm();
    t_swap_acc();
    t_port_in();
    t_unknown();
    t_reset();
    end_of_test();
  end
endmodule
